// [inc/msi_consts.svh]
// constants of the dual master selector: pointers, field positions, resets, timing
// assumes inclusion by bare name from the design file
`ifndef MSI_CONSTS_SVH
`define MSI_CONSTS_SVH

// fixed upper bits of the 7-bit slave address, low four come from the select pins
`define MSI_ADDR_HI      3'h7
// command byte
`define MSI_CMD_AI       4
`define MSI_CMD_RST      8'h00
`define MSI_PTR_IE       2'h0
`define MSI_PTR_CTL      2'h1
`define MSI_PTR_IST      2'h2
// irq enable register: bit 0 forwards the input, bits 3:1 mask the status flags
`define MSI_IE_INEN      0
`define MSI_IE_RST       8'h00
// control register
`define MSI_CTL_ON       0
`define MSI_CTL_INIT     1
`define MSI_CTL_RST      8'h00
// status register: flag positions, masks sit at the same positions in ie
`define MSI_IST_LOST     1
`define MSI_IST_DONE     2
`define MSI_IST_BUSY     3
`define MSI_EVT          3:1
`define MSI_IST_RST      8'h00
`define MSI_SYNC_RST     12'hfff
// recovery timing on the link clock
`define MSI_LINK_NS      32
`define MSI_REC_HALF_NS  5000
`define MSI_REC_HALF_CYC ((`MSI_REC_HALF_NS + `MSI_LINK_NS - 1) / `MSI_LINK_NS)
`define MSI_REC_PULSE_END 5'd20
`define MSI_REC_LAST     5'd22

`endif

// [inc/msi_pkg.sv]
// types shared by the dual master selector
// assumes nothing beyond the constants header
`default_nettype none

package msi_pkg;

	typedef struct packed {
		logic scl;
		logic sda;
	} msi_pin_s;

	typedef struct packed {
		logic [3:0]          addr;
		logic                rst_n;
		logic                irq_n;
		msi_pin_s            ds;
		msi_pin_s [1:0]      up;
	} msi_sync_s;

	typedef struct packed {
		logic [7:0] ie;
		logic [7:0] ctl;
		logic [7:0] ist;
	} msi_regs_s;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_RX   = 3'b001,
		S_ACK  = 3'b011,
		S_TX   = 3'b010,
		S_MACK = 3'b110
	} msi_i2c_st_e;

	typedef enum logic [1:0] {
		K_ADDR = 2'h0,
		K_CMD  = 2'h1,
		K_DATA = 2'h2
	} msi_kind_e;

endpackage

`default_nettype wire

// [rtl/msi_sel.sv]
// dual master selector: two upstream i2c slave ports, owner select, recovery, irq
// assumes sda/scl pins resolved outside from the enables; pass gates are external
`default_nettype none
`include "msi_consts.svh"

// ****************************************
// upstream register port
// ****************************************
module msi_slave
	import msi_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_ce,
	input  wire msi_pin_s   i_pin,
	input  wire logic [3:0] i_addr,
	input  wire logic [7:0] i_rdata,
	output logic [1:0]      o_cur_ptr,
	output logic            o_sda_oe,
	output logic            o_wr,
	output logic            o_rd,
	output logic [1:0]      o_ptr,
	output logic [7:0]      o_wdata
);
	msi_i2c_st_e st_r, st_nxt;
	msi_kind_e   kind_r, kind_nxt;
	msi_pin_s    prev_r;
	logic [7:0]  sh_r, sh_nxt, cmd_r, cmd_nxt, wd_r, wd_nxt;
	logic [3:0]  cnt_r, cnt_nxt;
	logic [1:0]  optr_r, optr_nxt;
	logic        rw_r, rw_nxt, oe_r, oe_nxt, wr_r, wr_nxt, rd_r, rd_nxt;
	logic        rise, fall, start, stop;

	// no timeouts: any scl rate down to a static clock is fine
	assign rise  = i_pin.scl & ~prev_r.scl;
	assign fall  = ~i_pin.scl & prev_r.scl;
	assign start = i_pin.scl & prev_r.scl & prev_r.sda & ~i_pin.sda;
	assign stop  = i_pin.scl & prev_r.scl & ~prev_r.sda & i_pin.sda;

	assign o_cur_ptr = cmd_r[1:0];
	assign o_sda_oe  = oe_r;
	assign o_wr      = wr_r;
	assign o_rd      = rd_r;
	assign o_ptr     = optr_r;
	assign o_wdata   = wd_r;

	always_comb begin
		st_nxt   = st_r;
		kind_nxt = kind_r;
		sh_nxt   = sh_r;
		cmd_nxt  = cmd_r;
		wd_nxt   = wd_r;
		cnt_nxt  = cnt_r;
		optr_nxt = optr_r;
		rw_nxt   = rw_r;
		oe_nxt   = oe_r;
		wr_nxt   = 1'b0;
		rd_nxt   = 1'b0;
		if (start) begin
			st_nxt   = S_RX;
			kind_nxt = K_ADDR;
			cnt_nxt  = 4'h0;
			oe_nxt   = 1'b0;
		end else if (stop) begin
			st_nxt = S_IDLE;
			oe_nxt = 1'b0;
		end else begin
			unique case (st_r)
				S_IDLE: begin
				end
				S_RX: begin
					if (rise) begin
						sh_nxt  = {sh_r[6:0], i_pin.sda};
						cnt_nxt = cnt_r + 4'h1;
					end else if (fall && cnt_r == 4'h8) begin
						cnt_nxt = 4'h0;
						st_nxt  = S_ACK;
						oe_nxt  = 1'b1;
						unique case (kind_r)
							K_ADDR: begin
								if (sh_r[7:1] == {`MSI_ADDR_HI, i_addr}) begin
									rw_nxt   = sh_r[0];
									kind_nxt = K_CMD;
								end else begin
									st_nxt = S_IDLE;
									oe_nxt = 1'b0;
								end
							end
							K_CMD: begin
								if (sh_r[7:5] == 3'h0 && sh_r[3:2] == 2'h0
									&& sh_r[1:0] != 2'h3) begin
									cmd_nxt  = sh_r;
									kind_nxt = K_DATA;
								end else begin
									st_nxt = S_IDLE;
									oe_nxt = 1'b0;
								end
							end
							default: begin
								if (cmd_r[1:0] != `MSI_PTR_IST) begin
									wr_nxt   = 1'b1;
									wd_nxt   = sh_r;
									optr_nxt = cmd_r[1:0];
									if (cmd_r[`MSI_CMD_AI])
										cmd_nxt[1:0] = cmd_r[1:0] + 2'h1;
								end else begin
									st_nxt = S_IDLE;
									oe_nxt = 1'b0;
								end
							end
						endcase
					end
				end
				S_ACK, S_MACK: begin
					// master ack after a read byte: load the next byte on its fall
					if (st_r == S_MACK && rise && i_pin.sda)
						st_nxt = S_IDLE;
					else if (fall) begin
						oe_nxt  = 1'b0;
						cnt_nxt = 4'h0;
						st_nxt  = S_RX;
						if (rw_r) begin
							st_nxt = S_TX;
							sh_nxt = i_rdata;
							oe_nxt = ~i_rdata[7];
							rd_nxt = 1'b1;
							optr_nxt = cmd_r[1:0];
							if (cmd_r[`MSI_CMD_AI])
								cmd_nxt[1:0] = (cmd_r[1:0] == `MSI_PTR_IST) ? 2'h0
									: cmd_r[1:0] + 2'h1;
						end
					end
				end
				S_TX: begin
					if (rise) begin
						cnt_nxt = cnt_r + 4'h1;
					end else if (fall) begin
						if (cnt_r == 4'h8) begin
							st_nxt = S_MACK;
							oe_nxt = 1'b0;
						end else begin
							sh_nxt = {sh_r[6:0], 1'b0};
							oe_nxt = ~sh_r[6];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_r   <= S_IDLE;
			kind_r <= K_ADDR;
			prev_r <= '1;
			sh_r   <= 8'h00;
			cmd_r  <= `MSI_CMD_RST;
			wd_r   <= 8'h00;
			cnt_r  <= 4'h0;
			optr_r <= 2'h0;
			rw_r   <= 1'b0;
			oe_r   <= 1'b0;
			wr_r   <= 1'b0;
			rd_r   <= 1'b0;
		end else if (i_ce) begin
			st_r   <= st_nxt;
			kind_r <= kind_nxt;
			prev_r <= i_pin;
			sh_r   <= sh_nxt;
			cmd_r  <= cmd_nxt;
			wd_r   <= wd_nxt;
			cnt_r  <= cnt_nxt;
			optr_r <= optr_nxt;
			rw_r   <= rw_nxt;
			oe_r   <= oe_nxt;
			wr_r   <= wr_nxt;
			rd_r   <= rd_nxt;
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst || !i_ce);

	a_cmd_nack: assert property ((st_r == S_RX && kind_r == K_CMD && fall && cnt_r == 4'h8
		&& sh_r[7:5] != 3'h0) |=> !o_sda_oe && st_r == S_IDLE)
		else $error("bad command byte was acknowledged");
	a_ist_nack: assert property ((st_r == S_RX && kind_r == K_DATA && fall && cnt_r == 4'h8
		&& cmd_r[1:0] == `MSI_PTR_IST) |=> !o_sda_oe && !o_wr)
		else $error("write to status register was acknowledged");
	a_rd_wrap: assert property ((st_r == S_ACK && fall && rw_r && !start && !stop
		&& cmd_r[`MSI_CMD_AI] && cmd_r[1:0] == `MSI_PTR_IST) |=> cmd_r[1:0] == 2'h0)
		else $error("read pointer did not wrap to zero");
endmodule

// ****************************************
// selector top
// ****************************************
module msi_sel
	import msi_pkg::*;
#(
	parameter bit START_CH0 = 1'b1
) (
	input  wire logic I_CLOCK,
	input  wire logic I_RST,
	input  wire logic I_CE,
	input  wire logic I_LINK_CLOCK,
	input  wire logic I_RESET_PIN_N,
	input  wire logic I_ADDR_SELECT_BIT0,
	input  wire logic I_ADDR_SELECT_BIT1,
	input  wire logic I_ADDR_SELECT_BIT2,
	input  wire logic I_ADDR_SELECT_BIT3,
	input  wire logic I_UPSTREAM_CLOCK_ZERO,
	input  wire logic I_UPSTREAM_DATA_ZERO,
	output logic      O_UPSTREAM_DATA_ZERO,
	output logic      O_UPSTREAM_DATA_ZERO_OE,
	input  wire logic I_UPSTREAM_CLOCK_ONE,
	input  wire logic I_UPSTREAM_DATA_ONE,
	output logic      O_UPSTREAM_DATA_ONE,
	output logic      O_UPSTREAM_DATA_ONE_OE,
	input  wire logic I_DOWNSTREAM_CLOCK,
	output logic      O_DOWNSTREAM_CLOCK,
	output logic      O_DOWNSTREAM_CLOCK_OE,
	input  wire logic I_DOWNSTREAM_DATA,
	output logic      O_DOWNSTREAM_DATA,
	output logic      O_DOWNSTREAM_DATA_OE,
	input  wire logic I_DOWNSTREAM_IRQ_N,
	output logic      O_UPSTREAM_IRQ_OUT_ZERO_N,
	output logic      O_UPSTREAM_IRQ_OUT_ONE_N,
	output logic      O_PASS_ZERO,
	output logic      O_PASS_ONE
);
	function automatic logic [1:0] own_code(input logic m);
		return m ? 2'h2 : 2'h1;
	endfunction

	function automatic logic irq_of(input msi_regs_s r, input logic act);
		return (|(r.ist[`MSI_EVT] & ~r.ie[`MSI_EVT])) | (act & r.ie[`MSI_IE_INEN]);
	endfunction

	function automatic logic [7:0] rdata_of(input msi_regs_s r, input logic [1:0] own,
		input logic [1:0] p, input logic act);
		unique case (p)
			`MSI_PTR_IE:  return r.ie;
			`MSI_PTR_CTL: return {4'h0, own, r.ctl[1:0]};
			default:      return {r.ist[7:1], act};
		endcase
	endfunction

	msi_sync_s  raw, s1_r, s2_r;
	msi_regs_s  regs_r [2];
	msi_regs_s  regs_nxt [2];
	logic [3:0] set_v [2];
	logic [3:0] clr_v [2];
	logic [1:0] sel_r, sel_nxt, irq_n_r, irq_n_nxt;
	logic [1:0] wr, rd, sda_oe;
	logic [1:0] wptr [2];
	logic [1:0] cptr [2];
	logic [7:0] wdat [2];
	logic       rst, int_act, ds_busy_r, ds_busy_nxt;
	msi_pin_s   ds_prev_r;
	logic       pend_r, pend_nxt, rbusy_r, rbusy_nxt, stgl_r, stgl_nxt;
	logic       dn_s1_r, dn_s2_r, dn_s3_r, done_evt;
	logic       l_rst1_r, l_rst2_r, l_ce1_r, l_ce2_r;
	logic       l_st1_r, l_st2_r, l_st3_r, l_done_r, l_done_nxt;
	logic       l_run_r, l_run_nxt, l_scl_r, l_scl_nxt, l_sda_r, l_sda_nxt;
	logic [4:0] l_step_r, l_step_nxt;
	logic [7:0] l_hc_r, l_hc_nxt;

	// ****************************************
	// pin synchronisers and reset
	// ****************************************
	assign raw = {I_ADDR_SELECT_BIT3, I_ADDR_SELECT_BIT2, I_ADDR_SELECT_BIT1,
		I_ADDR_SELECT_BIT0, I_RESET_PIN_N, I_DOWNSTREAM_IRQ_N,
		I_DOWNSTREAM_CLOCK, I_DOWNSTREAM_DATA, I_UPSTREAM_CLOCK_ONE,
		I_UPSTREAM_DATA_ONE, I_UPSTREAM_CLOCK_ZERO, I_UPSTREAM_DATA_ZERO};

	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			s1_r <= `MSI_SYNC_RST;
			s2_r <= `MSI_SYNC_RST;
		end else if (I_CE) begin
			s1_r <= raw;
			s2_r <= s1_r;
		end
	end

	assign rst     = I_RST | ~s2_r.rst_n;
	assign int_act = ~s2_r.irq_n;

	// ****************************************
	// upstream ports, one register set each
	// ****************************************
	for (genvar g = 0; g < 2; g++) begin : g_up
		msi_slave u_slave (
			.i_clk     (I_CLOCK),
			.i_rst     (rst),
			.i_ce      (I_CE),
			.i_pin     (s2_r.up[g]),
			.i_addr    (s2_r.addr),
			.i_rdata   (rdata_of(regs_r[g], {sel_r[1-g], sel_r[g]}, cptr[g], int_act)),
			.o_cur_ptr (cptr[g]),
			.o_sda_oe  (sda_oe[g]),
			.o_wr      (wr[g]),
			.o_rd      (rd[g]),
			.o_ptr     (wptr[g]),
			.o_wdata   (wdat[g])
		);
	end

	// ****************************************
	// ownership, flags and irq
	// ****************************************
	assign done_evt = dn_s2_r ^ dn_s3_r;

	always_comb begin
		sel_nxt     = sel_r;
		pend_nxt    = pend_r;
		rbusy_nxt   = rbusy_r;
		stgl_nxt    = stgl_r;
		regs_nxt    = regs_r;
		set_v       = '{default: 4'h0};
		clr_v       = '{default: 4'h0};
		ds_busy_nxt = ds_busy_r;
		// bus sensor: start sets busy, stop clears it
		if (ds_prev_r.scl && s2_r.ds.scl && ds_prev_r.sda != s2_r.ds.sda)
			ds_busy_nxt = ds_prev_r.sda;
		if (done_evt) begin
			sel_nxt   = own_code(pend_r);
			rbusy_nxt = 1'b0;
			set_v[pend_r][`MSI_IST_DONE] = 1'b1;
		end
		// master 0 is taken last and so wins a same-cycle tie, unless master 1 asks for recovery, which blocks it
		for (int i = 1; i >= 0; i--) begin
			if (wr[i] && wptr[i] == `MSI_PTR_IE)
				regs_nxt[i].ie = wdat[i];
			if (wr[i] && wptr[i] == `MSI_PTR_CTL) begin
				regs_nxt[i].ctl = wdat[i];
				if (!wdat[i][`MSI_CTL_ON]) begin
					if (sel_r[i])
						sel_nxt = 2'h0;
				end else if (!sel_r[i] && !rbusy_nxt) begin
					if (sel_r[1-i])
						set_v[1-i][`MSI_IST_LOST] = 1'b1;
					if (wdat[i][`MSI_CTL_INIT]) begin
						sel_nxt   = 2'h0;
						pend_nxt  = 1'(i);
						rbusy_nxt = 1'b1;
						stgl_nxt  = ~stgl_r;
					end else begin
						sel_nxt = own_code(1'(i));
						if (ds_busy_r)
							set_v[i][`MSI_IST_BUSY] = 1'b1;
					end
				end
			end
			if (rd[i] && wptr[i] == `MSI_PTR_IST)
				clr_v[i] = 4'he;
		end
		for (int i = 0; i < 2; i++) begin
			regs_nxt[i].ist = {4'h0, (regs_r[i].ist[3:0] & ~clr_v[i]) | set_v[i]};
			irq_n_nxt[i]    = ~irq_of(regs_r[i], int_act);
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (rst) begin
			sel_r     <= START_CH0 ? 2'h1 : 2'h0;
			pend_r    <= 1'b0;
			rbusy_r   <= 1'b0;
			stgl_r    <= 1'b0;
			regs_r    <= '{default: '{`MSI_IE_RST, `MSI_CTL_RST, `MSI_IST_RST}};
			irq_n_r   <= 2'h3;
			ds_busy_r <= 1'b0;
			ds_prev_r <= '1;
			dn_s1_r   <= 1'b0;
			dn_s2_r   <= 1'b0;
			dn_s3_r   <= 1'b0;
		end else if (I_CE) begin
			sel_r     <= sel_nxt;
			pend_r    <= pend_nxt;
			rbusy_r   <= rbusy_nxt;
			stgl_r    <= stgl_nxt;
			regs_r    <= regs_nxt;
			irq_n_r   <= irq_n_nxt;
			ds_busy_r <= ds_busy_nxt;
			ds_prev_r <= s2_r.ds;
			dn_s1_r   <= l_done_r;
			dn_s2_r   <= dn_s1_r;
			dn_s3_r   <= dn_s2_r;
		end
	end

	// ****************************************
	// recovery sequencer on the link clock
	// ****************************************

	always_comb begin
		l_run_nxt  = l_run_r;
		l_step_nxt = l_step_r;
		l_hc_nxt   = l_hc_r;
		l_done_nxt = l_done_r;
		if (!l_run_r) begin
			if (l_st2_r != l_st3_r) begin
				l_run_nxt  = 1'b1;
				l_step_nxt = 5'd0;
				l_hc_nxt   = 8'h00;
			end
		end else if (l_hc_r == 8'(`MSI_REC_HALF_CYC - 1)) begin
			l_hc_nxt = 8'h00;
			if (l_step_r == `MSI_REC_LAST) begin
				l_run_nxt  = 1'b0;
				l_done_nxt = ~l_done_r;
			end else
				l_step_nxt = l_step_r + 5'd1;
		end else
			l_hc_nxt = l_hc_r + 8'h01;
		// ten pulses (nine plus the nack one), then stop
		l_scl_nxt = l_run_nxt && ((l_step_nxt < `MSI_REC_PULSE_END) ? !l_step_nxt[0]
			: l_step_nxt == `MSI_REC_PULSE_END);
		l_sda_nxt = l_run_nxt && (l_step_nxt == `MSI_REC_PULSE_END
			|| l_step_nxt == `MSI_REC_PULSE_END + 5'd1);
	end

	always_ff @(posedge I_LINK_CLOCK) begin
		l_rst1_r <= rst;
		l_rst2_r <= l_rst1_r;
		l_ce1_r  <= I_CE;
		l_ce2_r  <= l_ce1_r;
		if (l_rst2_r) begin
			l_st1_r  <= 1'b0;
			l_st2_r  <= 1'b0;
			l_st3_r  <= 1'b0;
			l_done_r <= 1'b0;
			l_run_r  <= 1'b0;
			l_step_r <= 5'd0;
			l_hc_r   <= 8'h00;
			l_scl_r  <= 1'b0;
			l_sda_r  <= 1'b0;
		end else if (l_ce2_r) begin
			l_st1_r  <= stgl_r;
			l_st2_r  <= l_st1_r;
			l_st3_r  <= l_st2_r;
			l_done_r <= l_done_nxt;
			l_run_r  <= l_run_nxt;
			l_step_r <= l_step_nxt;
			l_hc_r   <= l_hc_nxt;
			l_scl_r  <= l_scl_nxt;
			l_sda_r  <= l_sda_nxt;
		end
	end

	assign O_PASS_ZERO               = sel_r[0];
	assign O_PASS_ONE                = sel_r[1];
	assign O_UPSTREAM_DATA_ZERO      = 1'b0;
	assign O_UPSTREAM_DATA_ZERO_OE   = sda_oe[0];
	assign O_UPSTREAM_DATA_ONE       = 1'b0;
	assign O_UPSTREAM_DATA_ONE_OE    = sda_oe[1];
	assign O_DOWNSTREAM_CLOCK        = 1'b0;
	assign O_DOWNSTREAM_CLOCK_OE     = l_scl_r;
	assign O_DOWNSTREAM_DATA         = 1'b0;
	assign O_DOWNSTREAM_DATA_OE      = l_sda_r;
	assign O_UPSTREAM_IRQ_OUT_ZERO_N = irq_n_r[0];
	assign O_UPSTREAM_IRQ_OUT_ONE_N  = irq_n_r[1];

	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (rst || !I_CE);

	a_sel_onehot: assert property (!(O_PASS_ZERO && O_PASS_ONE))
		else $error("both masters connected");
	a_int_fwd: assert property ((int_act && regs_r[1].ie[`MSI_IE_INEN])
		|=> !O_UPSTREAM_IRQ_OUT_ONE_N)
		else $error("downstream irq not forwarded");
	a_lost_set: assert property (($past(sel_r) == 2'h1 && sel_r == 2'h2)
		|-> regs_r[0].ist[`MSI_IST_LOST])
		else $error("lost flag missing after takeover");
	a_mask_gate: assert property ((regs_r[0].ie == 8'h0e) |=> O_UPSTREAM_IRQ_OUT_ZERO_N)
		else $error("masked source raised irq");
	a_rec_isolate: assert property (rbusy_r |-> sel_r == 2'h0)
		else $error("master connected during recovery");
	a_done_own: assert property (done_evt |=> sel_r == own_code(pend_r)
		&& regs_r[pend_r].ist[`MSI_IST_DONE])
		else $error("recovery end not signalled");
	a_busy_flag: assert property ((wr[0] && wptr[0] == `MSI_PTR_CTL && wdat[0][`MSI_CTL_ON]
		&& !wdat[0][`MSI_CTL_INIT] && !sel_r[0] && !rbusy_r && ds_busy_r)
		|=> regs_r[0].ist[`MSI_IST_BUSY])
		else $error("busy switch not flagged");
	a_no_busy_rec: assert property (done_evt |=> $stable(regs_r[0].ist[`MSI_IST_BUSY])
		&& $stable(regs_r[1].ist[`MSI_IST_BUSY]))
		else $error("busy flag set by own recovery");
	a_busy_mask: assert property ((regs_r[1].ie == 8'h08 && regs_r[1].ist[2:1] == 2'h0)
		|=> O_UPSTREAM_IRQ_OUT_ONE_N)
		else $error("disabled busy irq asserted");
endmodule

`default_nettype wire

// [dv/msi_mst_bfm.sv]
// partner: two bit-banged upstream i2c masters on the bench clock
// assumes resolved open-drain sda levels on i_sda and pull-ups on all lines
`default_nettype none

module msi_mst_bfm #(
	parameter int Q = 10
) (
	input  wire logic       i_clk,
	input  wire logic [1:0] i_sda,
	output logic      [1:0] o_scl,
	output logic      [1:0] o_sda
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_scl = 2'h3;
		o_sda = 2'h3;
	end

	// drive one master's lines at an edge, hold a quarter bit
	task automatic put(input int m, input logic c, input logic d);
		o_scl[m] <= c;
		o_sda[m] <= d;
		repeat (Q) @(posedge i_clk);
	endtask

	// start or repeated start, leaves clock low
	task automatic start(input int m);
		put(m, o_scl[m], 1'b1);
		put(m, 1'b1, 1'b1);
		put(m, 1'b1, 1'b0);
		put(m, 1'b0, 1'b0);
	endtask

	task automatic stop(input int m);
		put(m, 1'b0, 1'b0);
		put(m, 1'b1, 1'b0);
		put(m, 1'b1, 1'b1);
	endtask

	// eight bits msb first plus ninth bit; data only moves while clock is low
	task automatic xfer(input int m, input logic [7:0] d, input logic ack_in,
			output logic [7:0] q, output logic ack);
		logic [8:0] w;
		logic [8:0] r;
		w = {d, ack_in};
		for (int i = 8; i >= 0; i--) begin
			put(m, 1'b0, w[i]);
			put(m, 1'b1, w[i]);
			r[i] = i_sda[m];
			put(m, 1'b1, w[i]);
			put(m, 1'b0, w[i]);
		end
		q = r[8:1];
		ack = r[0];
	endtask
endmodule

`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the dual master selector
// assumes channel 0 owns after reset; open-drain wires and pass gates resolved here
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] AW = {3'h7, 4'h5, 1'b0};

	logic       clk        = 1'b0;
	logic       lclk       = 1'b0;
	logic       rst        = 1'b1;
	logic       rpin_n     = 1'b1;
	logic       irq_in_n   = 1'b1;
	logic       ce         = 1'b1;
	logic [3:0] addr_sel   = 4'h5;
	logic [1:0] m_scl;
	logic [1:0] m_sda;
	logic [1:0] up_sda;
	logic       oe0;
	logic       oe1;
	logic       scl_oe;
	logic       sda_oe;
	logic       irq0_n;
	logic       irq1_n;
	logic       pass0;
	logic       pass1;
	int         n_errors   = 0;
	int         cmp_count  = 0;
	int         pulses     = 0;
	int         short_half = 0;
	logic       rec_on     = 1'b0;
	logic       stop_seen  = 1'b0;
	realtime    t_edge     = 0.0;
	logic [7:0] bad [4]    = '{8'h03, 8'h24, 8'h80, 8'h13};

	wire logic du0    = m_sda[0] & ~oe0;
	wire logic du1    = m_sda[1] & ~oe1;
	wire logic ds_scl = ~scl_oe & (~pass0 | m_scl[0]) & (~pass1 | m_scl[1]);
	wire logic ds_sda = ~sda_oe & (~pass0 | du0) & (~pass1 | du1);
	wire logic scl0   = m_scl[0] & (~pass0 | ds_scl);
	wire logic scl1   = m_scl[1] & (~pass1 | ds_scl);
	assign up_sda[0] = du0 & (~pass0 | ds_sda);
	assign up_sda[1] = du1 & (~pass1 | ds_sda);

	always #2.5 clk = ~clk;
	always #16 lclk = ~lclk;

	// downstream watch: clock pulses with data high, phase lengths, stop
	always @(posedge ds_scl) if (rec_on) begin
		if (ds_sda)
			pulses++;
		if ($realtime - t_edge < 4700.0)
			short_half++;
		t_edge = $realtime;
	end
	always @(negedge ds_scl) if (rec_on) begin
		if ($realtime - t_edge < 4000.0)
			short_half++;
		t_edge = $realtime;
	end
	always @(posedge ds_sda) if (rec_on && ds_scl)
		stop_seen = 1'b1;

	msi_sel #(
		.START_CH0(1'b1)
	) dut_u (
		.I_CLOCK(clk), .I_RST(rst), .I_CE(ce), .I_LINK_CLOCK(lclk),
		.I_RESET_PIN_N(rpin_n),
		.I_ADDR_SELECT_BIT0(addr_sel[0]), .I_ADDR_SELECT_BIT1(addr_sel[1]),
		.I_ADDR_SELECT_BIT2(addr_sel[2]), .I_ADDR_SELECT_BIT3(addr_sel[3]),
		.I_UPSTREAM_CLOCK_ZERO(scl0), .I_UPSTREAM_DATA_ZERO(up_sda[0]),
		.O_UPSTREAM_DATA_ZERO(), .O_UPSTREAM_DATA_ZERO_OE(oe0),
		.I_UPSTREAM_CLOCK_ONE(scl1), .I_UPSTREAM_DATA_ONE(up_sda[1]),
		.O_UPSTREAM_DATA_ONE(), .O_UPSTREAM_DATA_ONE_OE(oe1),
		.I_DOWNSTREAM_CLOCK(ds_scl), .O_DOWNSTREAM_CLOCK(), .O_DOWNSTREAM_CLOCK_OE(scl_oe),
		.I_DOWNSTREAM_DATA(ds_sda), .O_DOWNSTREAM_DATA(), .O_DOWNSTREAM_DATA_OE(sda_oe),
		.I_DOWNSTREAM_IRQ_N(irq_in_n),
		.O_UPSTREAM_IRQ_OUT_ZERO_N(irq0_n), .O_UPSTREAM_IRQ_OUT_ONE_N(irq1_n),
		.O_PASS_ZERO(pass0), .O_PASS_ONE(pass1)
	);

	msi_mst_bfm bfm_u (.i_clk(clk), .i_sda(up_sda), .o_scl(m_scl), .o_sda(m_sda));

	// ****************************************
	// checks and transfers
	// ****************************************
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// order {pass1, pass0, irq1_n, irq0_n}
	task automatic pins(input logic [3:0] exp);
		repeat (10) @(posedge clk);
		@(negedge clk);
		chk({20'h0, pass1, pass0, irq1_n, irq0_n}, {20'h0, exp}, "pins");
	endtask

	// bytes[7:0] is the command; exp bit 0 is the address ack, bit k+1 that of byte k, set where refused or not sent
	task automatic wr(input int m, input logic [7:0] a, input logic [31:0] bytes,
			input int n, input logic [4:0] exp);
		logic [7:0] v;
		logic [4:0] nk;
		logic       b;
		nk = 5'h1f;
		bfm_u.start(m);
		bfm_u.xfer(m, a, 1'b1, v, nk[0]);
		for (int i = 0; i < n; i++) begin
			bfm_u.xfer(m, bytes[8 * i +: 8], 1'b1, v, b);
			nk[i + 1] = b;
		end
		bfm_u.stop(m);
		chk({19'h0, nk}, {19'h0, exp}, "acks");
	endtask

	task automatic rd(input int m, input logic [7:0] cmd, input int n,
			input logic [23:0] exp, input logic [23:0] msk = 24'hffffff);
		logic [7:0]  v;
		logic        b;
		logic [23:0] q;
		q = 24'h0;
		bfm_u.start(m);
		bfm_u.xfer(m, AW, 1'b1, v, b);
		bfm_u.xfer(m, cmd, 1'b1, v, b);
		bfm_u.start(m);
		bfm_u.xfer(m, AW | 8'h01, 1'b1, v, b);
		for (int i = 0; i < n; i++) begin
			bfm_u.xfer(m, 8'hff, i == n - 1, v, b);
			q[8 * i +: 8] = v;
		end
		bfm_u.stop(m);
		chk(q & msk, exp, "read");
	endtask

	task automatic final_report;
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		pins(4'b0111);
		rd(0, 8'h00, 1, 24'h00);
		wr(0, {3'h7, 4'h6, 1'b0}, 32'h00, 1, 5'h1f);
		foreach (bad[i]) wr(0, AW, {24'h0, bad[i]}, 1, 5'h1e);
		wr(0, AW, 32'h5502, 2, 5'h1c);
		wr(0, AW, 32'h0100, 2, 5'h18);
		rd(0, 8'h00, 1, 24'h01);
		rd(1, 8'h00, 1, 24'h00);
		irq_in_n <= 1'b0;
		pins(4'b0110);
		irq_in_n <= 1'b1;
		pins(4'b0111);
		ce <= 1'b0;
		irq_in_n <= 1'b0;
		pins(4'b0111);
		irq_in_n <= 1'b1;
		ce <= 1'b1;
		pins(4'b0111);
		wr(1, AW, 32'h55000210, 4, 5'h10);
		rd(1, 8'h12, 3, 24'h080200);
		wr(1, AW, 32'h0101, 2, 5'h18);
		pins(4'b1010);
		rd(0, 8'h02, 1, 24'h02);
		rd(0, 8'h02, 1, 24'h00);
		pins(4'b1011);
		wr(0, AW, 32'h0101, 2, 5'h18);
		pins(4'b0111);
		bfm_u.start(0);
		wr(1, AW, 32'h0101, 2, 5'h18);
		pins(4'b1000);
		bfm_u.stop(0);
		rd(1, 8'h02, 1, 24'h08, 24'h08);
		rd(0, 8'h02, 1, 24'h02);
		wr(0, AW, 32'h0900, 2, 5'h18);
		bfm_u.start(1);
		wr(0, AW, 32'h0101, 2, 5'h18);
		pins(4'b0111);
		bfm_u.stop(1);
		rec_on = 1'b1;
		wr(1, AW, 32'h0301, 2, 5'h18);
		pins(4'b0010);
		for (int i = 0; i < 40000 && pass1 !== 1'b1; i++) @(posedge clk);
		rec_on = 1'b0;
		chk(24'(pulses), 24'd10, "pulses");
		chk({23'h0, stop_seen}, 24'h1, "stop");
		chk(24'(short_half), 24'h0, "phase");
		pins(4'b1000);
		rd(1, 8'h02, 1, 24'h04, 24'h04);
		rpin_n <= 1'b0;
		pins(4'b0111);
		rpin_n <= 1'b1;
		repeat (10) @(posedge clk);
		rd(1, 8'h00, 1, 24'h00);
		final_report;
	end

	initial begin
		#500000;
		n_errors++;
		$display("wrong value at %0t: watchdog expired", $time);
		final_report;
	end
endmodule

`default_nettype wire
